// ---- logic/synth_cfg_pkg.sv ----
// constants shared by the synthesizer configuration loader
`default_nettype none
package synth_cfg_pkg;
  // ****************************************
  // configuration field widths
  // ****************************************
  localparam int M_W     = 9;                 // feedback divider value
  localparam int N_W     = 2;                 // output divider code
  localparam int T_W     = 2;                 // test select pair
  localparam int FRAME_W = 13;                // serial frame length
  localparam int CNT_W   = 9;                 // half-period counters
  // frame layout, msb shifted first
  localparam int FRM_M_LSB = 0;
  localparam int FRM_N_LSB = 9;
  localparam int FRM_T_LSB = 11;
  // output divide value for each code, plain defaults
  localparam logic [CNT_W-1:0] N_DIV_TABLE [4] = '{9'h001, 9'h002, 9'h004, 9'h008};
  // test output selections
  localparam logic [T_W-1:0] TSEL_LOW   = 2'h0;
  localparam logic [T_W-1:0] TSEL_SDATA = 2'h1;
  localparam logic [T_W-1:0] TSEL_FB    = 2'h2;
  localparam logic [T_W-1:0] TSEL_SYN   = 2'h3;
  // reset values
  localparam logic [M_W-1:0]     M_RST     = 9'h000;
  localparam logic [N_W-1:0]     N_RST     = 2'h0;
  localparam logic [T_W-1:0]     T_RST     = 2'h0;
  localparam logic [FRAME_W-1:0] SHIFT_RST = 13'h0000;
  localparam logic [CNT_W-1:0]   CNT_ONE   = 9'h001;
  // ****************************************
  // register map on the bus
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h4;
  localparam logic [ADDR_W-1:0] REG_SHIFT   = 4'h8;
  localparam int CTRL_HALT_BIT  = 0;
  localparam int STAT_M_LSB     = 0;
  localparam int STAT_N_LSB     = 9;
  localparam int STAT_T_LSB     = 11;
  localparam int STAT_SER_BIT   = 13;
  localparam int STAT_PAR_BIT   = 14;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {SEL_STATUS, SEL_CONTROL, SEL_SHIFT, SEL_NONE} reg_sel_t;
endpackage
`default_nettype wire

// ---- logic/synth_divider_config_loader.sv ----
// configuration loader, dividers and test mux of the synthesizer
`default_nettype none
module synth_divider_config_loader
  import synth_cfg_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RSTN,
  // register bus
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  // programming pins
  input  wire logic              PARALLEL_LATCH_STROBE_N,
  input  wire logic [M_W-1:0]    FEEDBACK_DIV_BITS,
  input  wire logic [N_W-1:0]    OUTPUT_DIV_BITS,
  input  wire logic              SERIAL_CLOCK,
  input  wire logic              SERIAL_DATA,
  input  wire logic              SERIAL_LOAD,
  // clocking pins
  input  wire logic              OSC_IN,
  input  wire logic              CRYSTAL_REF,
  input  wire logic              TEST_CLOCK_IN,
  input  wire logic              REFERENCE_SOURCE_SELECT,
  input  wire logic              MASTER_DIVIDER_RESET,
  input  wire logic              OUTPUT_DRIVE_EN0,
  input  wire logic              OUTPUT_DRIVE_EN1,
  output logic                   REFERENCE_OUT,
  output logic                   FEEDBACK_DIV_OUT,
  output logic                   SYNTHESIZED_CLOCK,
  output logic                   CLOCK_OUT0,
  output logic                   CLOCK_OUT0_OE_N,
  output logic                   CLOCK_OUT1,
  output logic                   CLOCK_OUT1_OE_N,
  output logic                   TEST_OUT
);

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_sync_r;          // release chain
  logic       rst_n;               // synchronised reset

  // assert at once, release after two edges
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ****************************************
  // helpers
  // ****************************************
  // true on the last count before a toggle; the compare is not an equality
  // so a count left above a newly lowered limit toggles at once, not after wrapping
  function automatic logic last_half(input logic [CNT_W-1:0] cnt,
                                     input logic [CNT_W-1:0] lim);
    last_half = (cnt >= lim - CNT_ONE);
  endfunction

  // address decode, shared by read and write paths
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
    unique case (a)
      REG_STATUS:  decode = SEL_STATUS;
      REG_CONTROL: decode = SEL_CONTROL;
      REG_SHIFT:   decode = SEL_SHIFT;
      default:     decode = SEL_NONE;
    endcase
  endfunction

  // ****************************************
  // configuration state
  // ****************************************
  logic [M_W-1:0]     m_r, m_nxt;        // feedback divide value
  logic [N_W-1:0]     n_r, n_nxt;        // output divider code
  logic [T_W-1:0]     t_r, t_nxt;        // test select pair
  logic [FRAME_W-1:0] sh_r, sh_nxt;      // serial shift register
  logic               pl_q_r;            // strobe of last cycle
  logic               sl_q_r;            // serial load of last cycle
  logic               sck_q_r;           // serial clock of last cycle
  logic               pl_rise;
  logic               sl_rise;
  logic               sck_rise;
  logic               serial_mode;       // parallel high, load low

  assign pl_rise     = PARALLEL_LATCH_STROBE_N & ~pl_q_r;
  assign sl_rise     = SERIAL_LOAD & ~sl_q_r;
  assign sck_rise    = SERIAL_CLOCK & ~sck_q_r;
  assign serial_mode = PARALLEL_LATCH_STROBE_N & ~SERIAL_LOAD;

  // next configuration; a serial event always beats an older latch
  always_comb begin
    m_nxt  = m_r;
    n_nxt  = n_r;
    t_nxt  = t_r;
    sh_nxt = sh_r;
    if (!PARALLEL_LATCH_STROBE_N) begin
      // strobe low: pins go straight to the dividers
      m_nxt = FEEDBACK_DIV_BITS;
      n_nxt = OUTPUT_DIV_BITS;
    end else if (pl_rise) begin
      // edge cycle: the pin value is captured and then held
      m_nxt = FEEDBACK_DIV_BITS;
      n_nxt = OUTPUT_DIV_BITS;
    end else if (sck_rise) begin
      sh_nxt = {sh_r[FRAME_W-2:0], SERIAL_DATA};
      if (SERIAL_LOAD) begin
        // load held high: shifted data reaches the dividers at once
        m_nxt = sh_nxt[FRM_M_LSB +: M_W];
        n_nxt = sh_nxt[FRM_N_LSB +: N_W];
        t_nxt = sh_nxt[FRM_T_LSB +: T_W];
      end
    end else if (sl_rise) begin
      m_nxt = sh_r[FRM_M_LSB +: M_W];
      n_nxt = sh_r[FRM_N_LSB +: N_W];
      t_nxt = sh_r[FRM_T_LSB +: T_W];
    end
    // load falling or level: values and shift register stay put
  end

  // register configuration; master reset leaves it alone
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      m_r     <= M_RST;
      n_r     <= N_RST;
      t_r     <= T_RST;
      sh_r    <= SHIFT_RST;
      pl_q_r  <= 1'b0;
      sl_q_r  <= 1'b0;
      sck_q_r <= 1'b0;
    end else begin
      m_r     <= m_nxt;
      n_r     <= n_nxt;
      t_r     <= t_nxt;
      sh_r    <= sh_nxt;
      pl_q_r  <= PARALLEL_LATCH_STROBE_N;
      sl_q_r  <= SERIAL_LOAD;
      sck_q_r <= SERIAL_CLOCK;
    end
  end

  // ****************************************
  // dividers and output pins
  // ****************************************
  logic             halt_r, halt_nxt;     // software divider hold
  logic             osc_q_r;              // oscillator of last cycle
  logic             osc_edge;             // either oscillator edge
  logic             div_hold;             // dividers held in reset
  logic [CNT_W-1:0] fb_cnt_r, fb_cnt_nxt; // feedback half periods
  logic             fb_r, fb_nxt;         // feedback divider output
  logic [CNT_W-1:0] od_cnt_r, od_cnt_nxt; // output half periods
  logic             syn_r, syn_nxt;       // synthesized clock
  logic [CNT_W-1:0] n_div;                // decoded divide value
  logic             test_r, test_nxt;     // test output
  logic             ref_r, ref_nxt;       // selected reference

  assign osc_edge = OSC_IN ^ osc_q_r;
  assign div_hold = MASTER_DIVIDER_RESET | halt_r;
  assign n_div    = N_DIV_TABLE[n_r];

  // counting both oscillator edges gives 50 percent duty even for odd
  // divide values, at the price of needing the osc below half of CLK
  always_comb begin
    fb_cnt_nxt = fb_cnt_r;
    fb_nxt     = fb_r;
    od_cnt_nxt = od_cnt_r;
    syn_nxt    = syn_r;
    if (div_hold) begin
      // held: counters cleared and outputs low
      fb_cnt_nxt = '0;
      fb_nxt     = 1'b0;
      od_cnt_nxt = '0;
      syn_nxt    = 1'b0;
    end else if (osc_edge) begin
      // zero divide value stops the feedback divider
      if (m_r != M_RST) begin
        if (last_half(fb_cnt_r, m_r)) begin
          fb_cnt_nxt = '0;
          fb_nxt     = ~fb_r;
        end else begin
          fb_cnt_nxt = fb_cnt_r + CNT_ONE;
        end
      end
      if (last_half(od_cnt_r, n_div)) begin
        od_cnt_nxt = '0;
        syn_nxt    = ~syn_r;
      end else begin
        od_cnt_nxt = od_cnt_r + CNT_ONE;
      end
    end
  end

  // test mux and reference select
  always_comb begin
    ref_nxt = REFERENCE_SOURCE_SELECT ? CRYSTAL_REF : TEST_CLOCK_IN;
    if (!PARALLEL_LATCH_STROBE_N) begin
      test_nxt = 1'b0;
    end else begin
      unique case (t_r)
        TSEL_LOW:   test_nxt = 1'b0;
        TSEL_SDATA: test_nxt = SERIAL_DATA;
        TSEL_FB:    test_nxt = fb_nxt;
        TSEL_SYN:   test_nxt = syn_nxt;
      endcase
    end
  end

  // register dividers and pin outputs
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      osc_q_r  <= 1'b0;
      fb_cnt_r <= '0;
      fb_r     <= 1'b0;
      od_cnt_r <= '0;
      syn_r    <= 1'b0;
      test_r   <= 1'b0;
      ref_r    <= 1'b0;
    end else begin
      osc_q_r  <= OSC_IN;
      fb_cnt_r <= fb_cnt_nxt;
      fb_r     <= fb_nxt;
      od_cnt_r <= od_cnt_nxt;
      syn_r    <= syn_nxt;
      test_r   <= test_nxt;
      ref_r    <= ref_nxt;
    end
  end

  assign REFERENCE_OUT     = ref_r;
  assign FEEDBACK_DIV_OUT  = fb_r;
  assign SYNTHESIZED_CLOCK = syn_r;
  assign TEST_OUT          = test_r;
  // both outputs carry the same divided clock, each with its own enable
  assign CLOCK_OUT0        = syn_r;
  assign CLOCK_OUT1        = syn_r;
  assign CLOCK_OUT0_OE_N   = ~OUTPUT_DRIVE_EN0;
  assign CLOCK_OUT1_OE_N   = ~OUTPUT_DRIVE_EN1;

  // ****************************************
  // register bus slave
  // ****************************************
  logic              aw_full_r, aw_full_nxt;   // write address held
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic              w_full_r, w_full_nxt;     // write data held
  logic [31:0]       w_data_r, w_data_nxt;
  logic [3:0]        w_strb_r, w_strb_nxt;
  logic              bvalid_r, bvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic [1:0]        rresp_r, rresp_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  logic [31:0]       status_word;              // live configuration view

  // a new write is refused until its response has been taken
  assign AWREADY = ~aw_full_r & ~bvalid_r;
  assign WREADY  = ~w_full_r & ~bvalid_r;
  assign ARREADY = ~rvalid_r;
  assign BVALID  = bvalid_r;
  assign BRESP   = bresp_r;
  assign RVALID  = rvalid_r;
  assign RRESP   = rresp_r;
  assign RDATA   = rdata_r;

  always_comb begin
    status_word = '0;
    status_word[STAT_M_LSB +: M_W] = m_r;
    status_word[STAT_N_LSB +: N_W] = n_r;
    status_word[STAT_T_LSB +: T_W] = t_r;
    status_word[STAT_SER_BIT]      = serial_mode;
    status_word[STAT_PAR_BIT]      = ~PARALLEL_LATCH_STROBE_N;
  end

  // write and read channel bookkeeping
  always_comb begin
    aw_full_nxt = aw_full_r;
    aw_addr_nxt = aw_addr_r;
    w_full_nxt  = w_full_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    halt_nxt    = halt_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    if (AWVALID && AWREADY) begin
      aw_full_nxt = 1'b1;
      aw_addr_nxt = AWADDR;
    end
    if (WVALID && WREADY) begin
      w_full_nxt = 1'b1;
      w_data_nxt = WDATA;
      w_strb_nxt = WSTRB;
    end
    if (aw_full_r && w_full_r) begin
      // both halves present: commit and answer next cycle
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RESP_OKAY;
      unique case (decode(aw_addr_r))
        SEL_CONTROL: begin
          if (w_strb_r[0]) begin
            halt_nxt = w_data_r[CTRL_HALT_BIT];
          end
        end
        SEL_STATUS, SEL_SHIFT: begin
          // read-only words ignore the data
        end
        SEL_NONE: bresp_nxt = RESP_SLVERR;
      endcase
    end else if (bvalid_r && BREADY) begin
      bvalid_nxt = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      unique case (decode(ARADDR))
        SEL_STATUS:  rdata_nxt = status_word;
        SEL_CONTROL: rdata_nxt = {31'h00000000, halt_r};
        SEL_SHIFT:   rdata_nxt = {19'h00000, sh_r};
        SEL_NONE: begin
          rdata_nxt = '0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && RREADY) begin
      rvalid_nxt = 1'b0;
    end
  end

  // register bus state
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= '0;
      w_full_r  <= 1'b0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      halt_r    <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= '0;
    end else begin
      aw_full_r <= aw_full_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_full_r  <= w_full_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      halt_r    <= halt_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

endmodule
`default_nettype wire

// ---- test/synth_divider_config_loader_asserts.sv ----
// port checker for the synthesizer configuration loader
`default_nettype none
module loader_checks (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PARALLEL_LATCH_STROBE_N,
  input wire logic SERIAL_LOAD,
  input wire logic CRYSTAL_REF,
  input wire logic TEST_CLOCK_IN,
  input wire logic REFERENCE_SOURCE_SELECT,
  input wire logic MASTER_DIVIDER_RESET,
  input wire logic OUTPUT_DRIVE_EN0,
  input wire logic OUTPUT_DRIVE_EN1,
  input wire logic REFERENCE_OUT,
  input wire logic FEEDBACK_DIV_OUT,
  input wire logic SYNTHESIZED_CLOCK,
  input wire logic CLOCK_OUT0,
  input wire logic CLOCK_OUT0_OE_N,
  input wire logic CLOCK_OUT1,
  input wire logic CLOCK_OUT1_OE_N,
  input wire logic TEST_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // reset release tracking
  // ****************************************
  logic [2:0] live_r;   // one stage beyond the design's two-flop release
  logic [2:0] live_nxt; // shifted-in ones
  // checks wait out the internal reset, else outputs still held at zero look wrong
  always_comb begin
    live_nxt = {live_r[1:0], 1'b1};
  end
  // register the release chain
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      live_r <= 3'h0;
    end else begin
      live_r <= live_nxt;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!live_r[2]);
  // ****************************************
  // assertions
  // ****************************************
  test_par_low_a: assert property (!PARALLEL_LATCH_STROBE_N |=> !TEST_OUT)
    else $error("test output high in parallel mode");
  oe0_track_a: assert property (CLOCK_OUT0_OE_N == !OUTPUT_DRIVE_EN0)
    else $error("output 0 enable mismatch");
  oe1_track_a: assert property (CLOCK_OUT1_OE_N == !OUTPUT_DRIVE_EN1)
    else $error("output 1 enable mismatch");
  mr_hold_a: assert property (MASTER_DIVIDER_RESET [*2] |-> !FEEDBACK_DIV_OUT && !CLOCK_OUT0)
    else $error("divider outputs not low under master reset");
  out0_copy_a: assert property (CLOCK_OUT0 == SYNTHESIZED_CLOCK)
    else $error("clock output 0 differs from synthesized clock");
  out1_copy_a: assert property (CLOCK_OUT1 == SYNTHESIZED_CLOCK)
    else $error("clock output 1 differs from synthesized clock");
  ref_xtal_a: assert property (REFERENCE_SOURCE_SELECT |=> REFERENCE_OUT == $past(CRYSTAL_REF))
    else $error("reference not the crystal");
  ref_test_a: assert property (!REFERENCE_SOURCE_SELECT |=> REFERENCE_OUT == $past(TEST_CLOCK_IN))
    else $error("reference not the test clock");
  // main scenarios reached
  cover property (PARALLEL_LATCH_STROBE_N && $rose(SERIAL_LOAD));
  cover property (MASTER_DIVIDER_RESET [*3]);
  cover property (PARALLEL_LATCH_STROBE_N && $rose(TEST_OUT));
endmodule
bind synth_divider_config_loader loader_checks chk (
  .CLK, .RSTN, .PARALLEL_LATCH_STROBE_N, .SERIAL_LOAD, .CRYSTAL_REF, .TEST_CLOCK_IN,
  .REFERENCE_SOURCE_SELECT, .MASTER_DIVIDER_RESET, .OUTPUT_DRIVE_EN0, .OUTPUT_DRIVE_EN1,
  .REFERENCE_OUT, .FEEDBACK_DIV_OUT, .SYNTHESIZED_CLOCK, .CLOCK_OUT0, .CLOCK_OUT0_OE_N,
  .CLOCK_OUT1, .CLOCK_OUT1_OE_N, .TEST_OUT
);
`default_nettype wire

// ---- test/prog_pin_host.sv ----
// host model driving the parallel and serial programming pins
`default_nettype none
module prog_pin_host
  import synth_cfg_pkg::*;
(
  input  wire logic           clk,
  output logic                strobe_n,
  output logic [M_W-1:0]      fb_bits,
  output logic [N_W-1:0]      out_bits,
  output logic                sclk,
  output logic                sdata,
  output logic                sload
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // pin sequences
  // ****************************************
  // hardwired default, strobe held low from power-up
  initial begin
    strobe_n = 1'b0;
    fb_bits = 9'h01b;
    out_bits = 2'h1;
    sclk = 1'b0;
    sdata = 1'b0;
    sload = 1'b0;
  end
  // every level stands two cycles so the design sees each change
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pins(input logic [M_W-1:0] m, input logic [N_W-1:0] n);
    fb_bits <= m;
    out_bits <= n;
    hold(2);
  endtask
  task automatic par(input logic [M_W-1:0] m, input logic [N_W-1:0] n, input logic latch);
    strobe_n <= 1'b0;
    pins(m, n);
    if (latch) begin
      strobe_n <= 1'b1;
      hold(2);
    end
  endtask
  // serial clock idles low outside frames
  task automatic frame(input logic [T_W-1:0] t, input logic [N_W-1:0] n,
                       input logic [M_W-1:0] m);
    logic [FRAME_W-1:0] f;
    f = {t, n, m};
    strobe_n <= 1'b1;
    for (int i = FRAME_W - 1; i >= 0; i--) begin
      sdata <= f[i];
      hold(2);
      sclk <= 1'b1;
      hold(2);
      sclk <= 1'b0;
    end
    sdata <= 1'b0; // released line sits at its pull-down
    hold(2);
  endtask
  task automatic load(input logic v);
    sload <= v;
    hold(2);
  endtask
  task automatic data(input logic v);
    @(posedge clk);
    sdata <= v;
  endtask
endmodule
`default_nettype wire

// ---- test/synth_divider_config_loader_tb_top.sv ----
// self-checking bench for the synthesizer configuration loader
`default_nettype none
module synth_divider_config_loader_tb_top;
  import synth_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWREADY, WREADY, BVALID;
  logic ARREADY, RVALID, OSC_IN, CRYSTAL_REF, TEST_CLOCK_IN, REFERENCE_SOURCE_SELECT;
  logic MASTER_DIVIDER_RESET, OUTPUT_DRIVE_EN0, OUTPUT_DRIVE_EN1, REFERENCE_OUT, TEST_OUT;
  logic FEEDBACK_DIV_OUT, SYNTHESIZED_CLOCK, CLOCK_OUT0, CLOCK_OUT0_OE_N, CLOCK_OUT1;
  logic CLOCK_OUT1_OE_N, SERIAL_CLOCK, SERIAL_DATA, SERIAL_LOAD, PARALLEL_LATCH_STROBE_N;
  logic [ADDR_W-1:0] AWADDR, ARADDR;
  logic [31:0]       WDATA, RDATA;
  logic [3:0]        WSTRB;
  logic [1:0]        BRESP, RRESP;
  logic [M_W-1:0]    FEEDBACK_DIV_BITS;
  logic [N_W-1:0]    OUTPUT_DIV_BITS;
  int                n_mismatch, n_tests, cyc;
  synth_divider_config_loader uut (
    .CLK, .RSTN, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP,
    .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
    .PARALLEL_LATCH_STROBE_N, .FEEDBACK_DIV_BITS, .OUTPUT_DIV_BITS, .SERIAL_CLOCK,
    .SERIAL_DATA, .SERIAL_LOAD, .OSC_IN, .CRYSTAL_REF, .TEST_CLOCK_IN,
    .REFERENCE_SOURCE_SELECT, .MASTER_DIVIDER_RESET, .OUTPUT_DRIVE_EN0, .OUTPUT_DRIVE_EN1,
    .REFERENCE_OUT, .FEEDBACK_DIV_OUT, .SYNTHESIZED_CLOCK, .CLOCK_OUT0, .CLOCK_OUT0_OE_N,
    .CLOCK_OUT1, .CLOCK_OUT1_OE_N, .TEST_OUT
  );
  prog_pin_host host (.clk(CLK), .strobe_n(PARALLEL_LATCH_STROBE_N),
    .fb_bits(FEEDBACK_DIV_BITS), .out_bits(OUTPUT_DIV_BITS), .sclk(SERIAL_CLOCK),
    .sdata(SERIAL_DATA), .sload(SERIAL_LOAD));
  // ****************************************
  // clocks, slow sources and timeout
  // ****************************************
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  // oscillator toggles every 3 cycles, so a half period is 3 per counted edge
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc % 3 == 2) OSC_IN <= ~OSC_IN;
    if (cyc % 5 == 4) CRYSTAL_REF <= ~CRYSTAL_REF;
    if (cyc % 7 == 6) TEST_CLOCK_IN <= ~TEST_CLOCK_IN;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // ****************************************
  // compare and bus tasks
  // ****************************************
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp32({31'h0, got}, {31'h0, exp});
  endtask
  task automatic cmpn(input int got, input int exp);
    cmp32(got, exp);
  endtask
  // address and data offered together, each released once taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er,
                    input logic [3:0] s = 4'hf);
    logic pa, pw, ta, tw;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge CLK);
      ta = pa && AWREADY === 1'b1;
      tw = pw && WREADY === 1'b1;
      @(posedge CLK);
      if (ta) AWVALID <= 1'b0;
      if (tw) WVALID <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do @(negedge CLK); while (BVALID !== 1'b1);
    cmp32({30'h0, BRESP}, {30'h0, er});
    @(posedge CLK);
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(negedge CLK); while (ARREADY !== 1'b1);
    @(posedge CLK);
    ARVALID <= 1'b0;
    do @(negedge CLK); while (RVALID !== 1'b1);
    cmp32(RDATA, ed);
    cmp32({30'h0, RRESP}, {30'h0, er});
    @(posedge CLK);
    RREADY <= 1'b0;
  endtask
  function automatic logic [31:0] st(logic [1:0] t, logic [1:0] n, logic [8:0] m,
                                     logic s, logic p);
    return {17'h0, p, s, t, n, m};
  endfunction
  // test output checked only once its source has stood four samples
  task automatic watch(input int t, input int n);
    logic [3:0] h;
    logic       src;
    h = 4'h5;
    repeat (n) begin
      @(negedge CLK);
      src = (t == 1) ? SERIAL_DATA : (t == 2) ? FEEDBACK_DIV_OUT :
            (t == 3) ? SYNTHESIZED_CLOCK : 1'b0;
      h = {h[2:0], src};
      if (h == 4'h0 || h == 4'hf) cmp1(TEST_OUT, h[0]);
    end
  endtask
  task automatic run_len(input int s, output int n);
    logic v;
    v = s ? SYNTHESIZED_CLOCK : FEEDBACK_DIV_OUT;
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while ((s ? SYNTHESIZED_CLOCK : FEEDBACK_DIV_OUT) === v);
  endtask
  // first two runs may still carry the old divide count
  task automatic halves(input int s, input int exp);
    int n;
    @(negedge CLK);
    repeat (2) run_len(s, n);
    repeat (2) begin
      run_len(s, n);
      cmpn(n, exp);
    end
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY, MASTER_DIVIDER_RESET} = '0;
    {OSC_IN, CRYSTAL_REF, TEST_CLOCK_IN, AWADDR, ARADDR, WDATA, WSTRB} = '0;
    {REFERENCE_SOURCE_SELECT, OUTPUT_DRIVE_EN0, OUTPUT_DRIVE_EN1} = 3'h7;
    {n_mismatch, n_tests, cyc} = '0;
    repeat (10) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (4) @(posedge CLK);
    rd(REG_STATUS, st(2'h0, 2'h1, 9'h01b, 1'b0, 1'b1), RESP_OKAY);
    host.par(9'h01e, 2'h2, 1'b0);
    rd(REG_STATUS, st(2'h0, 2'h2, 9'h01e, 1'b0, 1'b1), RESP_OKAY);
    host.par(9'h01e, 2'h2, 1'b1);
    host.pins(9'h019, 2'h3);
    rd(REG_STATUS, st(2'h0, 2'h2, 9'h01e, 1'b1, 1'b0), RESP_OKAY);
    host.frame(2'h3, 2'h2, 9'h01d);
    host.pins(9'h01f, 2'h0);
    rd(REG_SHIFT, {19'h0, 2'h3, 2'h2, 9'h01d}, RESP_OKAY);
    rd(REG_STATUS, st(2'h0, 2'h2, 9'h01e, 1'b1, 1'b0), RESP_OKAY);
    host.load(1'b1);
    rd(REG_STATUS, st(2'h3, 2'h2, 9'h01d, 1'b0, 1'b0), RESP_OKAY);
    host.load(1'b0);
    rd(REG_STATUS, st(2'h3, 2'h2, 9'h01d, 1'b1, 1'b0), RESP_OKAY);
    host.load(1'b1);
    host.frame(2'h1, 2'h1, 9'h01a);
    rd(REG_STATUS, st(2'h1, 2'h1, 9'h01a, 1'b0, 1'b0), RESP_OKAY);
    host.load(1'b0);
    for (int t = 0; t < 4; t++) begin
      host.frame(t[1:0], 2'h1, 9'h019);
      host.load(1'b1);
      host.load(1'b0);
      for (int k = 0; k < 4; k++) begin
        host.data(k[0]);
        watch(t, 20);
      end
    end
    host.par(9'h019, 2'h0, 1'b0);
    watch(0, 20);
    for (int c = 0; c < 4; c++) begin
      host.par(9'h019, c[1:0], 1'b0);
      halves(1, 3 * N_DIV_TABLE[c]);
    end
    host.par(9'h01f, 2'h3, 1'b0);
    halves(0, 3 * 31);
    @(posedge CLK);
    MASTER_DIVIDER_RESET <= 1'b1;
    repeat (3) @(negedge CLK);
    cmp1(CLOCK_OUT1, 1'b0);
    @(posedge CLK);
    MASTER_DIVIDER_RESET <= 1'b0;
    rd(REG_STATUS, st(2'h3, 2'h3, 9'h01f, 1'b0, 1'b1), RESP_OKAY);
    wr(REG_CONTROL, 32'h1, RESP_OKAY);
    rd(REG_CONTROL, 32'h1, RESP_OKAY);
    // low strobe byte off: the halt bit must not change
    wr(REG_CONTROL, 32'h0, RESP_OKAY, 4'he);
    rd(REG_CONTROL, 32'h1, RESP_OKAY);
    repeat (4) @(negedge CLK);
    cmp1(SYNTHESIZED_CLOCK, 1'b0);
    wr(REG_STATUS, 32'hffff_ffff, RESP_OKAY);
    rd(REG_STATUS, st(2'h3, 2'h3, 9'h01f, 1'b0, 1'b1), RESP_OKAY);
    rd(4'hc, 32'h0, RESP_SLVERR);
    wr(REG_CONTROL, 32'h0, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      @(posedge CLK);
      {REFERENCE_SOURCE_SELECT, OUTPUT_DRIVE_EN0, OUTPUT_DRIVE_EN1} <= i[2:0];
      repeat (12) @(negedge CLK);
      cmp1(CLOCK_OUT0_OE_N, !OUTPUT_DRIVE_EN0);
      cmp1(CLOCK_OUT1_OE_N, !OUTPUT_DRIVE_EN1);
    end
    complete_run();
  end
endmodule
`default_nettype wire
